// ==== core_cycle_cfg.svh ====
`ifndef CORE_CYCLE_CFG_SVH
`define CORE_CYCLE_CFG_SVH
`define WORD_W 16
`define ADDR_W 13
`define LOC_ADDR_W 12
`define MODULE_SEL_BIT 12
`define DIGIT_W 3
`define LINE_GROUPS 4
`define LINES_PER_GROUP 8
`define SIGN_BIT 15
`define MOST_NEGATIVE 16'h8000
`define MOST_POSITIVE 16'h7FFF
`define READ_TIME_NS 400
`define WRITE_TIME_NS 400
`define CLK_PERIOD_NS 10
`define READ_CYCLES ((`READ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8
`define DEST_MDR 0
`define DEST_W 5
`endif

// ==== core_cycle_pkg.sv ====
package core_cycle_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CLEAR = 3'b001,
        PH_READ = 3'b011,
        PH_MODIFY = 3'b010,
        PH_WRITE = 3'b110
    } phase_t;

    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_STORE_ACC = 2'b01,
        OP_INCR_SKIP = 2'b10
    } cycle_op_t;
endpackage : core_cycle_pkg

// ==== address_decoder.sv ====
`timescale 1ns/1ps
`include "core_cycle_cfg.svh"

module address_decoder (
    input wire logic [`LOC_ADDR_W-1:0] loc_addr,
    output logic [`LINES_PER_GROUP-1:0] x_low,
    output logic [`LINES_PER_GROUP-1:0] x_high,
    output logic [`LINES_PER_GROUP-1:0] y_low,
    output logic [`LINES_PER_GROUP-1:0] y_high
);
    // one octal digit selects one of eight lines
    function automatic logic [`LINES_PER_GROUP-1:0] one_of_eight(input logic [`DIGIT_W-1:0] d);
        one_of_eight = 8'h01 << d;
    endfunction : one_of_eight

    always_comb begin
        x_low = one_of_eight(loc_addr[2:0]);
        x_high = one_of_eight(loc_addr[5:3]);
        y_low = one_of_eight(loc_addr[8:6]);
        y_high = one_of_eight(loc_addr[11:9]);
    end
endmodule : address_decoder

// ==== core_memory_cycle_control.sv ====
`timescale 1ns/1ps
`include "core_cycle_cfg.svh"

module core_memory_cycle_control (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cycle_start,
    input wire logic [`ADDR_W-1:0] mem_addr,
    input wire logic second_module_fitted,
    input wire logic execute_phase,
    input wire logic store_first_acc_instr,
    input wire logic store_second_acc_instr,
    input wire logic jump_subroutine_instr,
    input wire logic increment_skip_zero_instr,
    input wire logic [`WORD_W-1:0] acc_first,
    input wire logic [`WORD_W-1:0] acc_second,
    input wire logic [`WORD_W-1:0] sense_out,
    input wire logic [`WORD_W-1:0] bus_data,
    input wire logic [`DEST_W-1:0] store_select,
    input wire logic [`WORD_W-1:0] negate_in,
    output logic [`LINES_PER_GROUP-1:0] x_low,
    output logic [`LINES_PER_GROUP-1:0] x_high,
    output logic [`LINES_PER_GROUP-1:0] y_low,
    output logic [`LINES_PER_GROUP-1:0] y_high,
    output logic [1:0] read_strobe,
    output logic [1:0] write_strobe,
    output logic [`WORD_W-1:0] inhibit,
    output logic [`WORD_W-1:0] mem_data,
    output logic skip_zero,
    output logic cycle_busy,
    output logic cycle_done,
    output logic [`WORD_W-1:0] negate_out,
    output logic is_negative
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [`WORD_W-1:0] negate(input logic [`WORD_W-1:0] v);
        negate = (~v) + 16'h0001;
    endfunction : negate

    function automatic logic [`WORD_W-1:0] incr(input logic [`WORD_W-1:0] v);
        incr = v + 16'h0001;
    endfunction : incr

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        core_cycle_pkg::phase_t phase;
        core_cycle_pkg::cycle_op_t op;
        logic use_second_acc;
        logic module_sel;
        logic [`LOC_ADDR_W-1:0] loc_addr;
        logic [`CNT_W-1:0] count;
        logic [`WORD_W-1:0] mdr;
        logic skip_zero;
        logic done;
    } state_t;

    state_t cur;
    state_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        case (cur.phase)
            core_cycle_pkg::PH_IDLE: begin
                if (cycle_start) begin
                    next_cur.phase = core_cycle_pkg::PH_CLEAR;
                    next_cur.loc_addr = mem_addr[`LOC_ADDR_W-1:0];
                    // single module: bit 12 ignored
                    next_cur.module_sel = second_module_fitted & mem_addr[`MODULE_SEL_BIT];
                    next_cur.use_second_acc = store_second_acc_instr;
                    if (execute_phase && (store_first_acc_instr || store_second_acc_instr
                            || jump_subroutine_instr)) begin
                        next_cur.op = core_cycle_pkg::OP_STORE_ACC;
                    end else if (execute_phase && increment_skip_zero_instr) begin
                        next_cur.op = core_cycle_pkg::OP_INCR_SKIP;
                    end else begin
                        next_cur.op = core_cycle_pkg::OP_READ;
                    end
                end else if (store_select[`DEST_MDR]) begin
                    next_cur.mdr = bus_data;
                end
            end
            core_cycle_pkg::PH_CLEAR: begin
                next_cur.mdr = '0;
                next_cur.skip_zero = 1'b0;
                next_cur.count = '0;
                next_cur.phase = core_cycle_pkg::PH_READ;
            end
            core_cycle_pkg::PH_READ: begin
                if (cur.op == core_cycle_pkg::OP_STORE_ACC) begin
                    next_cur.mdr = cur.use_second_acc ? acc_second : acc_first;
                end else begin
                    next_cur.mdr = cur.mdr | sense_out;
                end
                next_cur.count = cur.count + 8'h01;
                if (cur.count == 8'(`READ_CYCLES - 1)) begin
                    next_cur.count = '0;
                    next_cur.phase = core_cycle_pkg::PH_MODIFY;
                end
            end
            core_cycle_pkg::PH_MODIFY: begin
                if (cur.op == core_cycle_pkg::OP_INCR_SKIP) begin
                    next_cur.mdr = incr(cur.mdr);
                    next_cur.skip_zero = (incr(cur.mdr) == 16'h0000);
                end
                next_cur.phase = core_cycle_pkg::PH_WRITE;
            end
            core_cycle_pkg::PH_WRITE: begin
                next_cur.count = cur.count + 8'h01;
                if (cur.count == 8'(`WRITE_CYCLES - 1)) begin
                    next_cur.count = '0;
                    next_cur.done = 1'b1;
                    next_cur.phase = core_cycle_pkg::PH_IDLE;
                end
            end
            default: begin
                next_cur.phase = core_cycle_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= '{phase: core_cycle_pkg::PH_IDLE, op: core_cycle_pkg::OP_READ,
                     default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // array drive
    // ------------------------------------------------------------
    address_decoder u_dec (
        .loc_addr(cur.loc_addr),
        .x_low(x_low),
        .x_high(x_high),
        .y_low(y_low),
        .y_high(y_high)
    );

    logic in_read;
    logic in_write;
    assign in_read = (cur.phase == core_cycle_pkg::PH_READ);
    assign in_write = (cur.phase == core_cycle_pkg::PH_WRITE);

    always_comb begin
        read_strobe = 2'b00;
        write_strobe = 2'b00;
        read_strobe[cur.module_sel] = in_read;
        write_strobe[cur.module_sel] = in_write;
    end

    // zero bits inhibit the write current so those cores stay zero
    assign inhibit = in_write ? ~cur.mdr : 16'h0000;
    assign mem_data = cur.mdr;
    assign skip_zero = cur.skip_zero;
    assign cycle_busy = (cur.phase != core_cycle_pkg::PH_IDLE);
    assign cycle_done = cur.done;
    assign negate_out = negate(negate_in);
    assign is_negative = negate_in[`SIGN_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_clear_then_read;
        (cur.phase == core_cycle_pkg::PH_CLEAR) ##1 (in_read && mem_data == 16'h0000);
    endsequence

    property p_clear_first;
        @(posedge ref_clk) disable iff (rst)
        (cycle_start && !cycle_busy) |=> s_clear_then_read;
    endproperty
    a_clear_first: assert property (p_clear_first) else $error("data not cleared");

    property p_one_strobe;
        @(posedge ref_clk) disable iff (rst)
        (read_strobe != 2'b11) && (second_module_fitted || !read_strobe[1]);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("two read strobes");

    property p_sense_or;
        @(posedge ref_clk) disable iff (rst)
        (in_read && cur.op == core_cycle_pkg::OP_READ) |=>
            (mem_data == ($past(mem_data) | $past(sense_out)));
    endproperty
    a_sense_or: assert property (p_sense_or) else $error("sense not merged");

    property p_inhibit;
        @(posedge ref_clk) disable iff (rst)
        in_write |-> (inhibit == ~mem_data);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit wrong");

    property p_store_acc;
        @(posedge ref_clk) disable iff (rst)
        (in_read && cur.op == core_cycle_pkg::OP_STORE_ACC && !cur.use_second_acc) |=>
            (mem_data == $past(acc_first));
    endproperty
    a_store_acc: assert property (p_store_acc) else $error("acc not loaded");

    property p_incr;
        @(posedge ref_clk) disable iff (rst)
        (cur.phase == core_cycle_pkg::PH_MODIFY && cur.op == core_cycle_pkg::OP_INCR_SKIP)
            |=> (in_write && mem_data == $past(mem_data) + 16'h0001
                 && skip_zero == (mem_data == 16'h0000));
    endproperty
    a_incr: assert property (p_incr) else $error("increment wrong");

    property p_negate;
        @(posedge ref_clk) disable iff (rst)
        (negate_in == 16'h8000) |-> (negate_out == 16'h8000);
    endproperty
    a_negate: assert property (p_negate) else $error("negate wrong");

    property p_bus_capture;
        @(posedge ref_clk) disable iff (rst)
        (!cycle_busy && !cycle_start && !store_select[`DEST_MDR]) |=>
            (mem_data == $past(mem_data));
    endproperty
    a_bus_capture: assert property (p_bus_capture) else $error("unselected capture");

    property p_write_len;
        @(posedge ref_clk) disable iff (rst)
        $rose(in_write) |-> in_write [*8] ##32 (in_write && !cycle_done)
            ##1 (cycle_done && !in_write);
    endproperty
    a_write_len: assert property (p_write_len) else $error("write length wrong");
endmodule : core_memory_cycle_control

// ==== core_array_model.sv ====
`timescale 1ns/1ps
`include "core_cycle_cfg.svh"

// ----------------------------------------
// two-module core array, destructive read
// ----------------------------------------
module core_array_model (
    input wire logic ref_clk,
    input wire logic [`LINES_PER_GROUP-1:0] x_low,
    input wire logic [`LINES_PER_GROUP-1:0] x_high,
    input wire logic [`LINES_PER_GROUP-1:0] y_low,
    input wire logic [`LINES_PER_GROUP-1:0] y_high,
    input wire logic [1:0] read_strobe,
    input wire logic [1:0] write_strobe,
    input wire logic [`WORD_W-1:0] inhibit,
    output logic [`WORD_W-1:0] sense_out
);
    logic [`WORD_W-1:0] mem [2][4096];
    logic [`WORD_W-1:0] noise = 16'hA5C3;
    logic [11:0] loc;
    logic sel;

    function automatic logic [2:0] enc(input logic [7:0] v);
        enc = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (v[i]) begin
                enc = i[2:0];
            end
        end
    endfunction : enc

    assign loc = {enc(y_high), enc(y_low), enc(x_high), enc(x_low)};
    assign sel = read_strobe[1] | write_strobe[1];
    // sense pulses once per read: the word is erased after the first cycle
    assign sense_out = (|read_strobe) ? mem[sel][loc] : noise;

    always @(posedge ref_clk) begin
        noise <= ~noise;
        if (|read_strobe) begin
            mem[sel][loc] <= 16'h0000;
        end
        if (|write_strobe) begin
            mem[sel][loc] <= ~inhibit;
        end
    end
endmodule : core_array_model

// ==== core_memory_cycle_control_tb.sv ====
`timescale 1ns/1ps
`include "core_cycle_cfg.svh"

module core_memory_cycle_control_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cycle_start = 1'b0;
    logic execute_phase = 1'b0;
    logic exec_en = 1'b1;
    logic second_module_fitted = 1'b1;
    logic store_first_acc_instr = 1'b0;
    logic store_second_acc_instr = 1'b0;
    logic jump_subroutine_instr = 1'b0;
    logic increment_skip_zero_instr = 1'b0;
    logic skip_zero, cycle_busy, cycle_done, is_negative;
    logic [12:0] mem_addr = 13'h0000;
    logic [15:0] acc_first = 16'h0000;
    logic [15:0] acc_second = 16'h0000;
    logic [15:0] bus_data = 16'h0000;
    logic [15:0] negate_in = 16'h0000;
    logic [15:0] sense_out, inhibit, mem_data, negate_out;
    logic [4:0] store_select = 5'h00;
    logic [7:0] x_low, x_high, y_low, y_high;
    logic [1:0] read_strobe, write_strobe;
    int fail_count = 0, num_checks = 0, cycles = 0;

    always #5 ref_clk = ~ref_clk;

    core_memory_cycle_control i_dut (.ref_clk(ref_clk), .rst(rst), .cycle_start(cycle_start),
        .mem_addr(mem_addr), .second_module_fitted(second_module_fitted),
        .execute_phase(execute_phase),
        .store_first_acc_instr(store_first_acc_instr),
        .store_second_acc_instr(store_second_acc_instr),
        .jump_subroutine_instr(jump_subroutine_instr),
        .increment_skip_zero_instr(increment_skip_zero_instr),
        .acc_first(acc_first), .acc_second(acc_second), .sense_out(sense_out),
        .bus_data(bus_data), .store_select(store_select), .negate_in(negate_in),
        .x_low(x_low), .x_high(x_high), .y_low(y_low), .y_high(y_high),
        .read_strobe(read_strobe), .write_strobe(write_strobe), .inhibit(inhibit),
        .mem_data(mem_data), .skip_zero(skip_zero), .cycle_busy(cycle_busy),
        .cycle_done(cycle_done), .negate_out(negate_out), .is_negative(is_negative));

    core_array_model i_core (.ref_clk(ref_clk), .x_low(x_low), .x_high(x_high),
        .y_low(y_low), .y_high(y_high), .read_strobe(read_strobe),
        .write_strobe(write_strobe), .inhibit(inhibit), .sense_out(sense_out));

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // one memory cycle; op = {incr-skip, jump, second store, first store}
    // ----------------------------------------
    task automatic run(input logic [12:0] a, input logic [3:0] op, input logic [15:0] exp);
        int n;
        logic [1:0] sel;
        @(negedge ref_clk);
        // without the second module bit 12 is ignored
        sel = (a[12] & second_module_fitted) ? 2'b10 : 2'b01;
        mem_addr = a;
        {increment_skip_zero_instr, jump_subroutine_instr, store_second_acc_instr,
            store_first_acc_instr} = op;
        execute_phase = exec_en & (|op);
        cycle_start = 1'b1;
        @(negedge ref_clk);
        cycle_start = 1'b0;
        repeat (5) @(negedge ref_clk);
        check({14'h0, read_strobe}, {14'h0, sel}, "read strobe module");
        check({x_high, x_low}, {8'h01 << a[5:3], 8'h01 << a[2:0]}, "x lines");
        check({y_high, y_low}, {8'h01 << a[11:9], 8'h01 << a[8:6]}, "y lines");
        repeat (40) @(negedge ref_clk);
        check({14'h0, write_strobe}, {14'h0, sel}, "write strobe module");
        check(inhibit, ~exp, "inhibit");
        n = 0;
        while (cycle_done !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check({15'h0, cycle_done}, 16'h0001, "cycle end");
        check(n[15:0], 16'((`READ_CYCLES + `WRITE_CYCLES + 2) - 45), "cycle length");
        check(mem_data, exp, "data register");
    endtask : run

    task automatic t_store_restore;
        acc_first = 16'h5A3C;
        acc_second = 16'hC3A5;
        run(13'h0ABC, 4'b0001, 16'h5A3C);
        run(13'h1ABC, 4'b0010, 16'hC3A5);
        run(13'h0ABC, 4'b0000, 16'h5A3C);
        run(13'h0ABC, 4'b0000, 16'h5A3C);
        run(13'h1ABC, 4'b0000, 16'hC3A5);
        run(13'h0F01, 4'b0100, 16'h5A3C);
        run(13'h0F01, 4'b0000, 16'h5A3C);
    endtask : t_store_restore

    task automatic t_incr_skip;
        acc_first = 16'hFFFF;
        run(13'h0777, 4'b0001, 16'hFFFF);
        run(13'h0777, 4'b1000, 16'h0000);
        check({15'h0, skip_zero}, 16'h0001, "skip on wrap");
        run(13'h0777, 4'b1000, 16'h0001);
        check({15'h0, skip_zero}, 16'h0000, "no skip");
        run(13'h0777, 4'b0000, 16'h0001);
    endtask : t_incr_skip

    task automatic t_negate;
        logic [15:0] v [4] = '{16'h0E00, 16'hF200, 16'h8000, 16'h7FFF};
        logic [15:0] e [4] = '{16'hF200, 16'h0E00, 16'h8000, 16'h8001};
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            negate_in = v[i];
            #1;
            check(negate_out, e[i], "negate");
            check({15'h0, is_negative}, {15'h0, v[i][15]}, "sign");
        end
    endtask : t_negate

    task automatic t_bus_capture;
        logic [15:0] old;
        old = mem_data;
        @(negedge ref_clk);
        bus_data = 16'h1234;
        store_select = 5'h02;
        @(negedge ref_clk);
        store_select = 5'h00;
        @(negedge ref_clk);
        check(mem_data, old, "unselected capture");
        store_select = 5'h01;
        @(negedge ref_clk);
        store_select = 5'h00;
        @(negedge ref_clk);
        check(mem_data, 16'h1234, "selected capture");
    endtask : t_bus_capture

    // ----------------------------------------
    // store outside execute phase, single-module strap
    // ----------------------------------------
    task automatic t_strap_and_phase;
        exec_en = 1'b0;
        acc_first = 16'h1111;
        run(13'h0ABC, 4'b0001, 16'h5A3C);
        exec_en = 1'b1;
        second_module_fitted = 1'b0;
        run(13'h1ABC, 4'b0000, 16'h5A3C);
        second_module_fitted = 1'b1;
    endtask : t_strap_and_phase

    // ----------------------------------------
    // reset in mid-cycle; the word read so far is lost
    // ----------------------------------------
    task automatic t_mid_reset;
        @(negedge ref_clk);
        mem_addr = 13'h0F01;
        cycle_start = 1'b1;
        @(negedge ref_clk);
        cycle_start = 1'b0;
        repeat (8) @(negedge ref_clk);
        check(mem_data, 16'h5A3C, "read before reset");
        rst = 1'b1;
        @(negedge ref_clk);
        check({14'h0, read_strobe}, 16'h0000, "strobe in reset");
        check({15'h0, cycle_busy}, 16'h0000, "busy in reset");
        check(mem_data, 16'h0000, "data in reset");
        rst = 1'b0;
        run(13'h0777, 4'b0000, 16'h0001);
    endtask : t_mid_reset

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        rst = 0;
        t_store_restore();
        t_incr_skip();
        t_strap_and_phase();
        t_negate();
        t_bus_capture();
        t_mid_reset();
        tally_and_finish();
    end
endmodule : core_memory_cycle_control_tb
